// ===== motion_io_pkg.sv
`default_nettype none
package motion_io_pkg;

	// task count of the multitask controller
	localparam int TASKS  = 4;
	localparam int AXI_AW = 4;

	// register byte offsets
	localparam logic [AXI_AW-1:0] CTRL_OFS = 4'h0;
	localparam logic [AXI_AW-1:0] STAT_OFS = 4'h4;
	localparam logic [AXI_AW-1:0] PIN_OFS  = 4'h8;
	localparam logic [AXI_AW-1:0] PROG_OFS = 4'hc;

	// control register fields
	localparam int CTRL_EXT_BIT  = 0;
	localparam int CTRL_CONT_BIT = 1;

	// status register fields
	localparam int STAT_SYS_LSB    = 0;
	localparam int STAT_SEQ_LSB    = 16;
	localparam int STAT_PAUSED_BIT = 18;
	localparam int STAT_HERR_BIT   = 19;
	localparam int STAT_GUARD_BIT  = 20;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// program number is the binary select plus one
	localparam logic [4:0] PROG_BASE = 5'h01;
	localparam logic [4:0] PROG_MAX  = 5'h10;

	// homing lockout after power-up
	localparam int unsigned CLK_HZ        = 200000000;
	localparam int unsigned GUARD_S       = 2;
	localparam int unsigned GUARD_CYC_DEF = GUARD_S * CLK_HZ;
	// cycle at which the power-up data init pulse fires, once inputs settled
	localparam logic [31:0] SETTLE_CYC    = 32'h0000_0004;

	typedef enum logic [1:0] {ST_IDLE, ST_HOMING, ST_RUN} seq_e;

	typedef struct packed {
		logic       home;
		logic       start;
		logic       stop;
		logic       rst;
		logic       single;
		logic       cont;
		logic       escape;
		logic       pause;
		logic [3:0] prog_sel;
		logic       pallet;
		logic       servo;
	} pins_s;

	typedef struct packed {
		logic             motion_busy;
		logic             homing_busy;
		logic             step_done;
		logic             program_end;
		logic             in_position;
		logic             need_home;
		logic             error_cond;
		logic             input_wait;
		logic             units_ready;
		logic             battery_low;
		logic             move_until_escape_command;
		logic [TASKS-1:0] task_inpos;
		logic [TASKS-1:0] task_homed;
	} core_s;

	typedef struct packed {
		logic             running;
		logic             error;
		logic             pos_done;
		logic             homed;
		logic             input_wait;
		logic             pausing;
		logic             ready;
		logic             battery_alarm;
		logic [TASKS-1:0] task_pos_done;
		logic [TASKS-1:0] task_homed;
	} sys_out_s;

	typedef struct packed {
		logic       home_go;
		logic       run_go;
		logic       step_mode;
		logic       halt_after_step;
		logic       decel_hold;
		logic       escape_go;
		logic       clear_error;
		logic       init_data;
		logic       hold_data;
		logic       servo_on;
		logic       pallet_mode;
		logic       ext_point;
		logic [4:0] prog_no;
	} cmd_s;

	typedef struct packed {
		logic              awvalid;
		logic [AXI_AW-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [AXI_AW-1:0] araddr;
		logic              rready;
	} axi_in_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_out_s;

endpackage : motion_io_pkg
`default_nettype wire

// ===== motion_system_io_handshake.sv
// Added by the designer: register access over AXI4-Lite and the address map.
`default_nettype none
// Contract
// RL1: homing input rising edge starts homing
// RL2: normal start resumes from stopped step
// RL3: stop blocks homing/start; normal halts after step
// RL4: reset clears error; normal only when stopped
// RL5: running shows execution, homing or motion
// RL6: error output follows error condition
// RL7: positioning done, kept low while paused
// RL8: homed high unless homing is needed
// RL9: single-step at start stops after each command
// RL10: hold or clear data by continuous-start level
// RL11: escape during move-until-escape stops the step
// RL12: pause decelerates; start resumes, reset cancels
// RL13: four select bits give program 1..16
// RL14: pallet input selects palletizing or sequential
// RL15: servo input energizes the servo
// RL16: input-wait output while program waits input
// RL17: pausing output once paused and stopped
// RL18: ready low while preparing, high when done; the code also keeps ready low until the power-up homing lockout ends
// RL19: per-task positioning done outputs
// RL20: per-task homed outputs
// RL21: battery alarm on low backup voltage
// RL22: assignable inputs act on rising edge
// RL23: pause, pausing, ready work in external mode
// RL24: every command input synchronised before detection
// RL25: external mode start launches selected table move
// RL26: sequencer holds command pulses 30 ms; the sequencer model holds them HOLD_CYC cycles (8)
// RL27: homing locked out 2 s; stop+homing errors
module motion_system_io_handshake
	import motion_io_pkg::*;
#(
	parameter int unsigned GUARD_CYCLES = GUARD_CYC_DEF
) (
	input  wire logic     aclk,
	input  wire logic     aresetn,
	input  wire axi_in_s  axi_in,
	output var  axi_out_s axi_out,
	input  wire pins_s    pins_in,
	input  wire core_s    core_in,
	output var  sys_out_s sys_out,
	output var  cmd_s     cmd_out
);

	typedef struct packed {
		pins_s             s1;
		pins_s             s2;
		pins_s             s3;
		pins_s             flt;
		seq_e              seq;
		logic              paused;
		logic              home_err;
		logic              guard_done;
		logic              ext_mode;
		logic              cont_en;
		logic [31:0]       guard_cnt;
		logic              aw_have;
		logic              w_have;
		logic [AXI_AW-1:0] awaddr;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		axi_out_s          axi;
		sys_out_s          sys;
		cmd_s              cmd;
	} st_s;

	st_s   st_q;
	st_s   st_d;
	pins_s rise;
	logic  home_ok;
	logic  blocked;

	// helpers from registered state only
	assign home_ok = st_q.guard_done && (st_q.seq == ST_IDLE) && !st_q.paused;
	assign blocked = st_q.flt.stop;

	assign axi_out = st_q.axi;
	assign sys_out = st_q.sys;
	assign cmd_out = st_q.cmd;

	// whole next state of the block
	always_comb begin
		st_d = st_q;

		// RL24 input synchroniser
		st_d.s1  = pins_in;
		st_d.s2  = st_q.s1;
		st_d.s3  = st_q.s2;
		// a bit only moves once the last two stages agree, which also rejects glitches
		st_d.flt = pins_s'((st_q.s2 & ~(st_q.s2 ^ st_q.s3)) | (st_q.flt & (st_q.s2 ^ st_q.s3)));
		// RL22 rising edge detect
		rise     = pins_s'(st_d.flt & ~st_q.flt);

		// one-cycle command pulses
		st_d.cmd.home_go     = 1'b0;
		st_d.cmd.run_go      = 1'b0;
		st_d.cmd.escape_go   = 1'b0;
		st_d.cmd.clear_error = 1'b0;
		st_d.cmd.init_data   = 1'b0;

		// RL27 power-up homing lockout
		if (!st_q.guard_done) begin
			st_d.guard_cnt = st_q.guard_cnt + 32'h0000_0001;
			if (st_q.guard_cnt == 32'(GUARD_CYCLES - 1)) begin
				st_d.guard_done = 1'b1;
			end
		end

		// RL10 power-up data init
		if (st_q.guard_cnt == SETTLE_CYC) begin
			st_d.cmd.init_data = 1'b1;
			st_d.cmd.hold_data = st_q.cont_en & st_q.flt.cont;
		end

		// RL12 pause request, both modes
		if (rise.pause) begin
			// RL23 pause in external mode
			st_d.paused = 1'b1;
		end

		if (rise.home) begin
			// RL3 stop blocks homing
			if (!blocked && home_ok) begin
				// RL1 homing launch
				st_d.cmd.home_go = 1'b1;
				st_d.seq         = ST_HOMING;
			end
		end else if (rise.start && !blocked) begin
			if (st_q.paused) begin
				// RL12 start resumes pause
				st_d.paused      = 1'b0;
				st_d.cmd.run_go  = 1'b1;
			end else if (st_q.ext_mode) begin
				// RL25 table point move
				st_d.cmd.run_go  = 1'b1;
			end else if (st_q.seq == ST_IDLE) begin
				// RL2 resume program run
				st_d.cmd.run_go    = 1'b1;
				st_d.seq           = ST_RUN;
				// RL9 single step capture
				st_d.cmd.step_mode = st_q.flt.single;
			end
		end

		// sequence progress; core raises homing_busy the cycle after home_go
		case (st_q.seq)
			ST_HOMING: begin
				if (!st_q.cmd.home_go && !core_in.homing_busy) begin
					st_d.seq = ST_IDLE;
				end
			end
			ST_RUN: begin
				// RL9 stop after step
				if (core_in.program_end ||
				    (core_in.step_done && (st_q.cmd.step_mode || st_q.flt.stop))) begin
					st_d.seq = ST_IDLE;
				end
			end
			default: begin
			end
		endcase

		// RL3 normal mode stop
		st_d.cmd.halt_after_step = st_q.flt.stop & ~st_q.ext_mode;

		// RL4 reset accepted when stopped
		if (rise.rst && (st_q.ext_mode || (st_q.seq == ST_IDLE))) begin
			st_d.cmd.clear_error = 1'b1;
			st_d.home_err        = 1'b0;
			// RL12 reset cancels pause
			st_d.paused          = 1'b0;
			// RL10 reset data init
			st_d.cmd.init_data   = 1'b1;
			st_d.cmd.hold_data   = st_q.cont_en & st_q.flt.cont;
		end

		// RL27 homing under stop errors; set placed after clear so it wins
		if (rise.home && blocked) begin
			st_d.home_err = 1'b1;
		end

		// RL11 escape ends move
		if (rise.escape && core_in.move_until_escape_command) begin
			st_d.cmd.escape_go = 1'b1;
		end

		// level commands toward the motion core
		st_d.cmd.decel_hold  = st_d.paused;
		// RL15 servo follows input
		st_d.cmd.servo_on    = st_d.flt.servo;
		// RL14 pallet mode select
		st_d.cmd.pallet_mode = st_d.flt.pallet;
		// RL13 program number
		st_d.cmd.prog_no     = {1'b0, st_d.flt.prog_sel} + PROG_BASE;
		st_d.cmd.ext_point   = st_q.ext_mode;

		// RL5 running output
		st_d.sys.running       = st_q.ext_mode ? (core_in.motion_busy | core_in.homing_busy)
		                                       : (st_q.seq != ST_IDLE);
		// RL6 error output
		st_d.sys.error         = core_in.error_cond | st_d.home_err;
		// RL7 positioning done
		st_d.sys.pos_done      = core_in.in_position & ~core_in.motion_busy & ~st_d.paused;
		// RL8 homed output
		st_d.sys.homed         = ~core_in.need_home;
		// RL16 input wait
		st_d.sys.input_wait    = core_in.input_wait;
		// RL17 pausing output
		st_d.sys.pausing       = st_d.paused & ~core_in.motion_busy;
		// RL18 ready after preparation; also waits out the lockout
		st_d.sys.ready         = core_in.units_ready & st_q.guard_done;
		// RL21 battery alarm
		st_d.sys.battery_alarm = core_in.battery_low;
		// RL19 per task positioning
		st_d.sys.task_pos_done = core_in.task_inpos;
		// RL20 per task homed
		st_d.sys.task_homed    = core_in.task_homed;

		// axi write address and data, taken in either order
		if (axi_in.awvalid && st_q.axi.awready) begin
			st_d.aw_have = 1'b1;
			st_d.awaddr  = axi_in.awaddr;
		end
		if (axi_in.wvalid && st_q.axi.wready) begin
			st_d.w_have = 1'b1;
			st_d.wdata  = axi_in.wdata;
			st_d.wstrb  = axi_in.wstrb;
		end
		if (st_q.axi.bvalid && axi_in.bready) begin
			st_d.axi.bvalid = 1'b0;
		end
		// a write completes only once the previous response has gone
		if (st_d.aw_have && st_d.w_have && !st_d.axi.bvalid) begin
			st_d.aw_have    = 1'b0;
			st_d.w_have     = 1'b0;
			st_d.axi.bvalid = 1'b1;
			st_d.axi.bresp  = RESP_OKAY;
			if (st_d.awaddr == CTRL_OFS) begin
				if (st_d.wstrb[0]) begin
					st_d.ext_mode = st_d.wdata[CTRL_EXT_BIT];
					st_d.cont_en  = st_d.wdata[CTRL_CONT_BIT];
				end
			end else if (st_d.awaddr == STAT_OFS || st_d.awaddr == PIN_OFS ||
			             st_d.awaddr == PROG_OFS) begin
				st_d.axi.bresp = RESP_OKAY;
			end else begin
				st_d.axi.bresp = RESP_SLVERR;
			end
		end
		st_d.axi.awready = ~st_d.aw_have;
		st_d.axi.wready  = ~st_d.w_have;

		// axi read, one outstanding
		if (st_q.axi.rvalid && axi_in.rready) begin
			st_d.axi.rvalid = 1'b0;
		end
		if (axi_in.arvalid && st_q.axi.arready) begin
			st_d.axi.rvalid = 1'b1;
			st_d.axi.rresp  = RESP_OKAY;
			st_d.axi.rdata  = 32'h0000_0000;
			if (axi_in.araddr == CTRL_OFS) begin
				st_d.axi.rdata[CTRL_EXT_BIT]  = st_q.ext_mode;
				st_d.axi.rdata[CTRL_CONT_BIT] = st_q.cont_en;
			end else if (axi_in.araddr == STAT_OFS) begin
				st_d.axi.rdata[STAT_SYS_LSB +: $bits(sys_out_s)] = st_q.sys;
				st_d.axi.rdata[STAT_SEQ_LSB +: $bits(seq_e)]     = st_q.seq;
				st_d.axi.rdata[STAT_PAUSED_BIT]                  = st_q.paused;
				st_d.axi.rdata[STAT_HERR_BIT]                    = st_q.home_err;
				st_d.axi.rdata[STAT_GUARD_BIT]                   = st_q.guard_done;
			end else if (axi_in.araddr == PIN_OFS) begin
				st_d.axi.rdata[$bits(pins_s)-1:0] = st_q.flt;
			end else if (axi_in.araddr == PROG_OFS) begin
				st_d.axi.rdata[4:0] = st_q.cmd.prog_no;
			end else begin
				st_d.axi.rresp = RESP_SLVERR;
			end
		end
		st_d.axi.arready = ~st_d.axi.rvalid;
	end

	// single state register, synchronous reset to all zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_start_pin_held;
		!pins_in.start ##1 pins_in.start [*4];
	endsequence

	sequence s_home_edge_free;
		$rose(st_q.flt.home) && $past(home_ok) && !$past(blocked);
	endsequence

	a_home_launch: assert property (s_home_edge_free |-> st_q.cmd.home_go && // RL1
		st_q.seq == ST_HOMING)
		else $error("homing edge did not launch homing");

	a_stop_blocks: assert property (st_q.flt.stop && $past(st_q.flt.stop) |-> // RL3
		!st_q.cmd.home_go && !st_q.cmd.run_go)
		else $error("command launched while stop held");

	a_stop_home_err: assert property ($rose(st_q.flt.home) && $past(blocked) |-> // RL27
		st_q.sys.error && st_q.home_err)
		else $error("homing under stop raised no error");

	a_guard_lockout: assert property (!$past(st_q.guard_done) |-> !st_q.cmd.home_go) // RL27
		else $error("homing launched inside power-up lockout");

	a_run_ext_map: assert property ($past(st_q.ext_mode) && $past(core_in.motion_busy) |-> // RL5
		st_q.sys.running)
		else $error("running low while moving in external mode");

	a_pause_posdone: assert property (st_q.paused && $past(st_q.paused) |-> // RL7
		!st_q.sys.pos_done)
		else $error("positioning done while paused");

	a_prog_range: assert property ($past(aresetn) |-> st_q.cmd.prog_no >= PROG_BASE && // RL13
		st_q.cmd.prog_no <= PROG_MAX)
		else $error("program number out of range");

	a_sync_delay: assert property (s_start_pin_held |-> ##[0:1] st_q.flt.start) // RL24
		else $error("start pin not seen after synchroniser");

	a_reset_gated: assert property ($past(!st_q.ext_mode) && // RL4
		$past(st_q.seq != ST_IDLE) |-> !st_q.cmd.clear_error)
		else $error("reset accepted while program runs");

	a_ready_guard: assert property (!$past(st_q.guard_done) |-> !st_q.sys.ready) // RL18
		else $error("ready high during preparation");

	a_reset_unpause: assert property (st_q.cmd.clear_error |-> !st_q.paused && // RL12
		!st_q.cmd.decel_hold)
		else $error("reset left pause active");

	a_error_map: assert property ($past(aresetn) |-> // RL6
		st_q.sys.error == ($past(core_in.error_cond) || st_q.home_err))
		else $error("error output does not follow error state");

	a_homed_map: assert property ($past(aresetn) |-> // RL8
		st_q.sys.homed == !$past(core_in.need_home))
		else $error("homed output does not follow homing need");

	a_pausing_map: assert property ($past(aresetn) |-> // RL17
		st_q.sys.pausing == (st_q.paused && !$past(core_in.motion_busy)))
		else $error("pausing output wrong");

	a_run_norm: assert property ($past(aresetn) && !$past(st_q.ext_mode) |-> // RL5
		st_q.sys.running == ($past(st_q.seq) != ST_IDLE))
		else $error("running does not follow the program sequence");

	a_escape_go: assert property ($rose(st_q.flt.escape) && // RL11
		$past(core_in.move_until_escape_command) |-> st_q.cmd.escape_go)
		else $error("escape edge did not end the move");

	a_task_posdone: assert property ($past(aresetn) |-> // RL19
		st_q.sys.task_pos_done == $past(core_in.task_inpos))
		else $error("task positioning outputs wrong");

	// a finished step under single operation must drop back to idle
	sequence s_single_step_done;
		st_q.seq == ST_RUN && st_q.cmd.step_mode && core_in.step_done;
	endsequence

	a_single_halt: assert property (s_single_step_done |=> st_q.seq == ST_IDLE) // RL9
		else $error("single operation did not stop after the step");

	sequence s_ext_start_edge;
		$rose(st_q.flt.start) && !$rose(st_q.flt.home) &&
		$past(st_q.ext_mode) && !$past(blocked);
	endsequence

	a_ext_start: assert property (s_ext_start_edge |-> st_q.cmd.run_go) // RL25
		else $error("external mode start launched no move");

	a_reset_init: assert property (st_q.cmd.clear_error |-> st_q.cmd.init_data && // RL10
		st_q.cmd.hold_data == ($past(st_q.cont_en) && $past(st_q.flt.cont)))
		else $error("reset did not apply the data hold choice");

	a_pause_ext: assert property ($rose(st_q.flt.pause) && $past(st_q.ext_mode) && // RL23
		!st_q.cmd.clear_error && !st_q.cmd.run_go |-> st_q.paused && st_q.cmd.decel_hold)
		else $error("pause ignored in external mode");

endmodule : motion_system_io_handshake
`default_nettype wire

// ===== motion_sequencer_model.sv
`default_nettype none
// host sequencer: turns one-cycle requests into held command pulses
module motion_sequencer_model
	import motion_io_pkg::*;
#(
	parameter int HOLD_CYC = 8
) (
	input  wire logic       aclk,
	input  wire logic [3:0] req,
	input  wire pins_s      lv,
	output var  pins_s      pins
);
	timeunit 1ns;
	timeprecision 1ps;

	int cnt [4] = '{0, 0, 0, 0};

	// pulse hold time
	// scaled hold, long enough for the input filter to see the pulse
	always @(posedge aclk) begin
		for (int i = 0; i < 4; i++) begin
			if (req[i])
				cnt[i] <= HOLD_CYC;
			else if (cnt[i] != 0)
				cnt[i] <= cnt[i] - 1;
		end
	end

	// levels pass through, pulses come from the hold counters
	always_comb begin
		pins       = lv;
		pins.home  = cnt[0] != 0;
		pins.start = cnt[1] != 0;
		pins.stop  = cnt[2] != 0;
		pins.rst   = cnt[3] != 0;
	end
endmodule : motion_sequencer_model
`default_nettype wire

// ===== motion_system_io_handshake_tb.sv
`default_nettype none
module motion_system_io_handshake_tb
	import motion_io_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic       aclk;
	logic       aresetn;
	axi_in_s    ax;
	axi_out_s   ao;
	pins_s      lv;
	pins_s      pins;
	core_s      core;
	core_s      cr;
	sys_out_s   so;
	cmd_s       co;
	logic [3:0] req;
	logic [31:0] rd;
	logic [1:0] rs;
	int n_errors = 0, total_checks = 0, n_home = 0, n_run = 0, n_clr = 0, h0, r0, c0;
	int n_esc = 0, e0;

	motion_sequencer_model i_motion_sequencer_model (
		.aclk(aclk), .req(req), .lv(lv), .pins(pins));

	// short lockout so the guard expires early in the run
	motion_system_io_handshake #(.GUARD_CYCLES(20)) i_motion_system_io_handshake (
		.aclk(aclk), .aresetn(aresetn), .axi_in(ax), .axi_out(ao),
		.pins_in(pins), .core_in(core), .sys_out(so), .cmd_out(co));

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	// count command pulses; scenarios compare deltas
	always @(posedge aclk) begin
		n_home <= n_home + int'(co.home_go === 1'b1);
		n_run  <= n_run + int'(co.run_go === 1'b1);
		n_clr  <= n_clr + int'(co.clear_error === 1'b1);
		n_esc  <= n_esc + int'(co.escape_go === 1'b1);
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	task automatic snap();
		h0 = n_home;
		r0 = n_run;
		c0 = n_clr;
		e0 = n_esc;
	endtask : snap

	// 0 home, 1 start, 2 stop, 3 reset request
	task automatic pulse(input int i, input int w);
		req[i] <= 1'b1;
		cyc(1);
		req[i] <= 1'b0;
		cyc(w);
	endtask : pulse

	// master releases each channel on its own handshake
	task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
		ax.awvalid <= 1'b1; ax.awaddr <= a; ax.wvalid <= 1'b1;
		ax.wdata <= d; ax.wstrb <= 4'hf; ax.bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (ax.awvalid && ao.awready) ax.awvalid <= 1'b0;
			if (ax.wvalid && ao.wready) ax.wvalid <= 1'b0;
			if (ao.bvalid) begin
				r = ao.bresp;
				ax.bready <= 1'b0;
				break;
			end
		end
		// let an edge pass so the next call never re-drives bready in this step
		cyc(1);
	endtask : axw

	task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		ax.arvalid <= 1'b1; ax.araddr <= a; ax.rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (ax.arvalid && ao.arready) ax.arvalid <= 1'b0;
			if (ao.rvalid) begin
				d = ao.rdata;
				r = ao.rresp;
				ax.rready <= 1'b0;
				break;
			end
		end
		cyc(1);
	endtask : axr

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	// main sequence
	initial begin
		ax = '0; lv = '0; core = '0; req = '0; aresetn = 1'b0;
		core.units_ready = 1'b1;
		lv.cont = 1'b1;
		void'($urandom(4));
		fork
			begin
				cyc(3000);
				n_errors++;
				end_of_test();
			end
		join_none
		cyc(16);
		aresetn <= 1'b1;
		snap();
		pulse(0, 14);
		chk("home_lock", n_home - h0, 0);
		cyc(20);
		axw(CTRL_OFS, 32'h1, rs);
		chk("wr_resp", rs, RESP_OKAY);
		cyc(2);
		chk("ext_point", co.ext_point, 1);
		// external mode: start launches a table move, running follows motion
		snap();
		pulse(1, 14);
		chk("ext_start", n_run - r0, 1);
		core.motion_busy <= 1'b1;
		cyc(3);
		chk("run_ext", so.running, 1);
		core.motion_busy <= 1'b0;
		lv.pause <= 1'b1;
		cyc(8);
		chk("ext_pausing", so.pausing, 1);
		pulse(3, 14);
		chk("ext_unpause", so.pausing, 0);
		lv.pause <= 1'b0;
		axr(CTRL_OFS, rd, rs);
		chk("ctrl_rd", rd[1:0], 2'h1);
		// back to normal mode with continuous start enabled
		axw(CTRL_OFS, 32'h2, rs);
		axr(STAT_OFS, rd, rs);
		chk("guard", rd[STAT_GUARD_BIT], 1);
		axr(4'h2, rd, rs);
		chk("unmapped", rs, RESP_SLVERR);
		snap();
		pulse(0, 14);
		chk("home_go", n_home - h0, 1);
		snap();
		pulse(1, 14);
		chk("run_go", n_run - r0, 1);
		chk("running", so.running, 1);
		snap();
		pulse(3, 14);
		chk("rst_busy", n_clr - c0, 0);
		// stop then a finished step halts the program
		pulse(2, 6);
		chk("halt_step", co.halt_after_step, 1);
		core.step_done <= 1'b1;
		cyc(1);
		core.step_done <= 1'b0;
		cyc(14);
		chk("halted", so.running, 0);
		snap();
		pulse(2, 1);
		pulse(1, 14);
		chk("start_blk", n_run - r0, 0);
		pulse(2, 1);
		pulse(0, 14);
		chk("home_err", so.error, 1);
		lv.single <= 1'b1;
		snap();
		pulse(3, 14);
		chk("rst_clr", n_clr - c0, 1);
		chk("err_clr", so.error, 0);
		chk("hold_data", co.hold_data, 1);
		// single operation: one finished step ends the run
		snap();
		pulse(1, 14);
		chk("step_mode", co.step_mode, 1);
		chk("run_single", n_run - r0, 1);
		core.step_done <= 1'b1;
		cyc(1);
		core.step_done <= 1'b0;
		cyc(3);
		chk("step_halt", so.running, 0);
		lv.single <= 1'b0;
		// pause while in position, then cancel by reset
		core.in_position <= 1'b1;
		lv.pause <= 1'b1;
		cyc(10);
		chk("pausing", so.pausing, 1);
		chk("pos_paused", so.pos_done, 0);
		chk("decel_hold", co.decel_hold, 1);
		pulse(3, 14);
		chk("pause_cxl", so.pausing, 0);
		chk("pos_done", so.pos_done, 1);
		lv.pause <= 1'b0;
		// escape only counts while a move-until-escape command runs
		snap();
		lv.escape <= 1'b1;
		cyc(8);
		lv.escape <= 1'b0;
		core.move_until_escape_command <= 1'b1;
		cyc(8);
		lv.escape <= 1'b1;
		cyc(8);
		chk("escape", n_esc - e0, 1);
		// random levels on selects and core status
		repeat (24) begin
			cr = $bits(core_s)'($urandom);
			cr.step_done = 1'b0; cr.program_end = 1'b0; cr.homing_busy = 1'b0;
			cr.move_until_escape_command = 1'b0; cr.motion_busy = 1'b0;
			core <= cr;
			lv.prog_sel <= 4'($urandom);
			lv.pallet <= 1'($urandom);
			lv.servo <= 1'($urandom);
			cyc(7);
			chk("prog_no", co.prog_no, {1'b0, lv.prog_sel} + 5'h01);
			chk("pallet", co.pallet_mode, lv.pallet);
			chk("servo", co.servo_on, lv.servo);
			chk("sys", {so.error, so.homed, so.input_wait, so.ready, so.battery_alarm,
				so.task_pos_done, so.task_homed}, {cr.error_cond, ~cr.need_home,
				cr.input_wait, cr.units_ready, cr.battery_low, cr.task_inpos,
				cr.task_homed});
		end
		end_of_test();
	end
endmodule : motion_system_io_handshake_tb
`default_nettype wire
